// ---- hdl/tone_xcvr_pkg.sv ----
// constants and types shared by the tone transceiver register block
package tone_xcvr_pkg;
  // ----------------------------------------------------------------------
  // register select values
  // ----------------------------------------------------------------------
  localparam logic SEL_DATA = 1'b0;
  localparam logic SEL_CTRL = 1'b1;
  // ----------------------------------------------------------------------
  // control register a field positions
  // ----------------------------------------------------------------------
  localparam int CRA_TONE_OUT  = 0;
  localparam int CRA_MODE      = 1;
  localparam int CRA_IRQ_EN    = 2;
  localparam int CRA_SEL_B     = 3;
  // ----------------------------------------------------------------------
  // control register b field positions
  // ----------------------------------------------------------------------
  localparam int CRB_NO_BURST  = 0;
  localparam int CRB_TEST      = 1;
  localparam int CRB_SINGLE    = 2;
  localparam int CRB_COLUMN    = 3;
  // ----------------------------------------------------------------------
  // status field positions
  // ----------------------------------------------------------------------
  localparam int ST_IRQ        = 0;
  localparam int ST_TX_READY   = 1;
  localparam int ST_RX_FULL    = 2;
  localparam int ST_DELAYED    = 3;
  // ----------------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------------
  localparam logic [3:0] CTRL_A_RESET = 4'h0;
  localparam logic [3:0] CTRL_B_RESET = 4'h0;
  localparam logic [3:0] CODE_RESET   = 4'h0;
  // ----------------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS   = 40;
  localparam int BURST_TIME_MS   = 51;
  localparam int BURST_CYCLES    = BURST_TIME_MS * 1000000 / CLK_PERIOD_NS;
  localparam int CNT_W           = 22;
  typedef enum logic [1:0] {TX_IDLE, TX_BURST, TX_PAUSE} burst_state_t;
endpackage

// ---- hdl/burst_timer.sv ----
// tone burst and pause sequencer with base or doubled-length timing
`timescale 1ns/1ps
module burst_timer #(
  parameter int BASE_CYCLES = tone_xcvr_pkg::BURST_CYCLES
) (
  // clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 reset_n,
  // control
  input  wire logic                 start,
  input  wire logic                 double_len,
  // status
  output logic                      burst_on,
  output logic                      done
);
  import tone_xcvr_pkg::*;

  burst_state_t           state_r;
  logic [CNT_W:0]         cnt_r;
  logic [CNT_W:0]         len;

  // call progress doubles burst and pause
  assign len = double_len ? (CNT_W+1)'(2 * BASE_CYCLES)
                          : (CNT_W+1)'(BASE_CYCLES);

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      state_r <= TX_IDLE;
      cnt_r   <= '0;
      done    <= 1'b0;
    end else begin
      done <= 1'b0;
      case (state_r)
        TX_IDLE: begin
          if (start) begin
            state_r <= TX_BURST;
            cnt_r   <= len - 1'b1;
          end
        end
        TX_BURST: begin
          if (cnt_r == '0) begin
            state_r <= TX_PAUSE;
            cnt_r   <= len - 1'b1;
          end else begin
            cnt_r <= cnt_r - 1'b1;
          end
        end
        TX_PAUSE: begin
          if (cnt_r == '0) begin
            state_r <= TX_IDLE;
            done    <= 1'b1;
          end else begin
            cnt_r <= cnt_r - 1'b1;
          end
        end
        default: state_r <= TX_IDLE;
      endcase
    end
  end

  assign burst_on = (state_r == TX_BURST);

  property p_burst_len;
    @(posedge core_clk) disable iff (!reset_n)
    $rose(burst_on) && !double_len |-> burst_on [*8];
  endproperty
  a_burst_len: assert property (p_burst_len)
    else $error("burst ended too early");
  property p_done_idle;
    @(posedge core_clk) disable iff (!reset_n)
    done |-> !burst_on && $past(state_r) == TX_PAUSE;
  endproperty
  a_done_idle: assert property (p_done_idle)
    else $error("ready pulse outside pause end");
endmodule

// ---- hdl/tone_xcvr_regs.sv ----
// host register bank and control logic of the tone transceiver
`timescale 1ns/1ps
module tone_xcvr_regs #(
  parameter int BURST_LEN = tone_xcvr_pkg::BURST_CYCLES
) (
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       reset_n,
  // host bus
  input  wire logic       chip_sel_n,
  input  wire logic       register_select_line,
  input  wire logic       read_not_write,
  input  wire logic       bus_strobe,
  input  wire logic [3:0] wdata,
  output logic      [3:0] rdata,
  output logic            rdata_oe,
  // receiver side
  input  wire logic       rx_valid,
  input  wire logic [3:0] rx_code,
  input  wire logic       rx_absent,
  input  wire logic       cp_tone_det,
  // transmitter side
  output logic      [3:0] tx_code,
  output logic            tone_on,
  output logic            single_tone,
  output logic            column_group,
  output logic            call_progress_mode,
  // shared interrupt / tone pin, open drain
  input  wire logic       interrupt_tone_pin_in,
  output logic            interrupt_tone_pin_out,
  output logic            interrupt_tone_pin_oe
);
  import tone_xcvr_pkg::*;

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  logic [3:0] control_reg_a_r;
  logic [3:0] control_reg_b_r;
  logic [3:0] rx_code_r;
  logic       ready_r;
  logic       full_r;
  logic       delayed_r;
  logic       irq_r;
  logic       b_next_r;
  logic       rd_pend_r;
  logic       rd_d_r;
  logic       burst_on;
  logic       burst_done;
  logic       bus_hit;
  logic       wr;
  logic       rd;
  logic       tx_wr;
  logic       rd_stat;
  logic       rd_end;
  logic       tone_mode_select;
  logic       no_burst;
  logic       irq_en;
  logic       pin_low;

  // pure: an assign only re-runs when the arguments change
  function automatic logic acc(input logic hit, input logic rnw,
                               input logic rs, input logic want_rd,
                               input logic sel);
    acc = hit && (rnw == want_rd) && (rs == sel);
  endfunction

  assign tone_mode_select = control_reg_a_r[CRA_MODE];
  assign no_burst         = control_reg_b_r[CRB_NO_BURST];
  assign irq_en           = control_reg_a_r[CRA_IRQ_EN];
  assign bus_hit          = !chip_sel_n && bus_strobe;
  assign wr               = acc(bus_hit, read_not_write, register_select_line,
                                1'b0, SEL_CTRL);
  assign tx_wr            = acc(bus_hit, read_not_write, register_select_line,
                                1'b0, SEL_DATA);
  assign rd_stat          = acc(bus_hit, read_not_write, register_select_line,
                                1'b1, SEL_CTRL);
  assign rd               = acc(bus_hit, read_not_write, register_select_line,
                                1'b1, SEL_DATA) || rd_stat;
  // strobe falling edge ends a pending status read cycle
  assign rd_end           = rd_d_r && !rd && rd_pend_r;

  // ----------------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      control_reg_a_r <= CTRL_A_RESET;
      control_reg_b_r <= CTRL_B_RESET;
      b_next_r        <= 1'b0;
    end else if (wr) begin
      if (b_next_r) begin
        control_reg_b_r <= wdata;
        b_next_r        <= 1'b0;
      end else begin
        control_reg_a_r <= wdata;
        b_next_r        <= wdata[CRA_SEL_B];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      tx_code <= CODE_RESET;
    end else if (tx_wr) begin
      tx_code <= wdata;
    end
  end

  // ----------------------------------------------------------------------
  // transmitter controls
  // ----------------------------------------------------------------------
  burst_timer #(
    .BASE_CYCLES (BURST_LEN)
  ) u_burst (
    .core_clk   (core_clk),
    .reset_n    (reset_n),
    .start      (tx_wr && !no_burst),
    .double_len (tone_mode_select),
    .burst_on   (burst_on),
    .done       (burst_done)
  );

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      tone_on            <= 1'b0;
      single_tone        <= 1'b0;
      column_group       <= 1'b0;
      call_progress_mode <= 1'b0;
    end else begin
      // non-burst: tone follows enable alone
      tone_on <= control_reg_a_r[CRA_TONE_OUT]
                 && (no_burst || burst_on);
      single_tone        <= control_reg_b_r[CRB_SINGLE];
      column_group       <= control_reg_b_r[CRB_COLUMN];
      call_progress_mode <= tone_mode_select;
    end
  end

  // ----------------------------------------------------------------------
  // receive code and flags
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      rx_code_r <= CODE_RESET;
    end else if (rx_valid && !tone_mode_select) begin
      rx_code_r <= rx_code;
    end
  end

  // tracks that a status read is in progress
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      rd_d_r    <= 1'b0;
      rd_pend_r <= 1'b0;
    end else begin
      rd_d_r <= rd;
      if (rd_stat) begin
        rd_pend_r <= 1'b1;
      end else if (rd_end) begin
        rd_pend_r <= 1'b0;
      end
    end
  end

  // set wins over clear in the same cycle
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      ready_r <= 1'b0;
    end else if (burst_done && !no_burst) begin
      ready_r <= 1'b1;
    end else if (rd_end || no_burst) begin
      ready_r <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      full_r <= 1'b0;
    end else if (rx_valid && !tone_mode_select) begin
      full_r <= 1'b1;
    end else if (rd_end) begin
      full_r <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      irq_r <= 1'b0;
    end else if ((burst_done && !no_burst)
                 || (rx_valid && !tone_mode_select)) begin
      irq_r <= 1'b1;
    end else if (rd_end) begin
      irq_r <= 1'b0;
    end
  end

  // read-proof: follows the receiver only
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      delayed_r <= 1'b0;
    end else if (rx_valid) begin
      delayed_r <= 1'b0;
    end else if (rx_absent) begin
      delayed_r <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------------
  // flags sampled before the clear at the end of the read
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      rdata <= 4'h0;
    end else if (rd_stat) begin
      rdata <= {delayed_r, full_r, ready_r, irq_r};
    end else if (rd) begin
      rdata <= rx_code_r;
    end
  end

  assign rdata_oe = rd_d_r;

  // ----------------------------------------------------------------------
  // interrupt / tone pin
  // ----------------------------------------------------------------------
  always_comb begin
    pin_low = 1'b0;
    if (control_reg_b_r[CRB_TEST]) begin
      pin_low = !delayed_r;
    end else if (irq_en && tone_mode_select) begin
      pin_low = cp_tone_det;
    end else if (irq_en) begin
      pin_low = irq_r;
    end
  end

  // drive only low, never high
  assign interrupt_tone_pin_out = 1'b0;
  assign interrupt_tone_pin_oe  = pin_low;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  property p_cp_no_decode;
    @(posedge core_clk) disable iff (!reset_n)
    tone_mode_select && !rd_end |=> $stable(rx_code_r) && !$rose(full_r);
  endproperty
  a_cp_no_decode: assert property (p_cp_no_decode)
    else $error("decode during call progress");
  property p_b_route;
    @(posedge core_clk) disable iff (!reset_n)
    wr && b_next_r |=> $stable(control_reg_a_r) && !b_next_r;
  endproperty
  a_b_route: assert property (p_b_route)
    else $error("control b write misrouted");
  property p_irq_pin;
    @(posedge core_clk) disable iff (!reset_n)
    irq_r && irq_en && !tone_mode_select && !control_reg_b_r[CRB_TEST]
    |-> interrupt_tone_pin_oe;
  endproperty
  a_irq_pin: assert property (p_irq_pin)
    else $error("interrupt not driven");
  property p_irq_or;
    @(posedge core_clk) disable iff (!reset_n)
    ready_r || full_r |-> irq_r;
  endproperty
  a_irq_or: assert property (p_irq_or)
    else $error("irq flag missing");
  property p_rd_clear;
    @(posedge core_clk) disable iff (!reset_n)
    rd_end && !rx_valid && !burst_done |=> !full_r && !irq_r;
  endproperty
  a_rd_clear: assert property (p_rd_clear)
    else $error("flags not cleared by read");
  property p_nb_ready;
    @(posedge core_clk) disable iff (!reset_n)
    no_burst |=> !ready_r;
  endproperty
  a_nb_ready: assert property (p_nb_ready)
    else $error("ready set in non-burst");
  property p_delayed;
    @(posedge core_clk) disable iff (!reset_n)
    rx_valid |=> !delayed_r;
  endproperty
  a_delayed: assert property (p_delayed)
    else $error("delayed steering not cleared");
  property p_test_pin;
    @(posedge core_clk) disable iff (!reset_n)
    control_reg_b_r[CRB_TEST] |-> interrupt_tone_pin_oe == !delayed_r;
  endproperty
  a_test_pin: assert property (p_test_pin)
    else $error("test pin wrong");
  property p_od;
    @(posedge core_clk) disable iff (!reset_n)
    interrupt_tone_pin_out == 1'b0;
  endproperty
  a_od: assert property (p_od)
    else $error("pin driven high");
  property p_stat_old;
    @(posedge core_clk) disable iff (!reset_n)
    rd_stat && !rd_pend_r |=> rdata[ST_RX_FULL] == $past(full_r);
  endproperty
  a_stat_old: assert property (p_stat_old)
    else $error("status read value wrong");
  property p_tx_write;
    @(posedge core_clk) disable iff (!reset_n)
    tx_wr |=> tx_code == $past(wdata);
  endproperty
  a_tx_write: assert property (p_tx_write)
    else $error("transmit code not stored");
  property p_ready_set;
    @(posedge core_clk) disable iff (!reset_n)
    burst_done && !no_burst |=> ready_r && irq_r;
  endproperty
  a_ready_set: assert property (p_ready_set)
    else $error("ready not set after pause");
  property p_rx_load;
    @(posedge core_clk) disable iff (!reset_n)
    rx_valid && !tone_mode_select |=> rx_code_r == $past(rx_code) && full_r;
  endproperty
  a_rx_load: assert property (p_rx_load)
    else $error("receive code not loaded");

  c_burst: cover property (@(posedge core_clk) burst_done);
  c_rx: cover property (@(posedge core_clk) $rose(full_r));
  c_rdclr: cover property (@(posedge core_clk) rd_end && irq_r);
  c_crb: cover property (@(posedge core_clk) wr && b_next_r);
  c_cp_pin: cover property (@(posedge core_clk)
    tone_mode_select && irq_en && interrupt_tone_pin_oe);
endmodule

// ---- sim/host_cpu.sv ----
// host processor model driving the parallel register port
`timescale 1ns/1ps
module host_cpu
  import tone_xcvr_pkg::*;
(
  // clock
  input  wire logic       core_clk,
  // bus towards the device
  output logic            chip_sel_n,
  output logic            register_select_line,
  output logic            read_not_write,
  output logic            bus_strobe,
  output logic      [3:0] wdata,
  input  wire logic [3:0] rdata
);
  initial begin
    chip_sel_n = 1'b1;
    register_select_line = 1'b0;
    read_not_write = 1'b1;
    bus_strobe = 1'b0;
    wdata = 4'hA;
  end
  // ------------------------------------------------------------------
  // bus cycles, one strobe cycle each
  // ------------------------------------------------------------------
  task automatic wr(input logic sel, input logic [3:0] d);
    @(posedge core_clk);
    #1;
    chip_sel_n = 1'b0;
    register_select_line = sel;
    read_not_write = 1'b0;
    bus_strobe = 1'b1;
    wdata = d;
    @(posedge core_clk);
    #1;
    chip_sel_n = 1'b1;
    bus_strobe = 1'b0;
    // released bus shows no stale value
    wdata = ~d;
  endtask
  task automatic rd(input logic sel, output logic [3:0] d);
    @(posedge core_clk);
    #1;
    chip_sel_n = 1'b0;
    register_select_line = sel;
    read_not_write = 1'b1;
    bus_strobe = 1'b1;
    @(posedge core_clk);
    #1;
    d = rdata;
    chip_sel_n = 1'b1;
    bus_strobe = 1'b0;
  endtask
  // ------------------------------------------------------------------
  // start-up sequence clearing control and status
  // ------------------------------------------------------------------
  task automatic init();
    logic [3:0] s;
    rd(SEL_CTRL, s);
    wr(SEL_CTRL, 4'h0);
    wr(SEL_CTRL, 4'h0);
    wr(SEL_CTRL, 4'h8);
    wr(SEL_CTRL, 4'h0);
    rd(SEL_CTRL, s);
  endtask
endmodule

// ---- sim/tone_xcvr_regs_tb.sv ----
// self-checking testbench of the tone transceiver register block
`timescale 1ns/1ps
module tone_xcvr_regs_tb;
  import tone_xcvr_pkg::*;
  localparam int BL = 10;
  logic       core_clk, reset_n, chip_sel_n, register_select_line;
  logic       read_not_write, bus_strobe, rdata_oe, rx_valid;
  logic       rx_absent, cp_tone_det, tone_on, single_tone;
  logic       column_group, call_progress_mode, pin_out, pin_oe, pin;
  logic [3:0] wdata, rdata, rx_code, tx_code, s;
  int         err_count, compares;
  time        t0;
  // open-drain pin with pull-up
  assign pin = pin_oe ? 1'b0 : 1'b1;
  always #20 core_clk = ~core_clk;
  host_cpu h (.core_clk(core_clk), .chip_sel_n(chip_sel_n),
    .register_select_line(register_select_line),
    .read_not_write(read_not_write), .bus_strobe(bus_strobe),
    .wdata(wdata), .rdata(rdata));
  tone_xcvr_regs #(.BURST_LEN(BL)) i_dut (.core_clk(core_clk),
    .reset_n(reset_n), .chip_sel_n(chip_sel_n),
    .register_select_line(register_select_line),
    .read_not_write(read_not_write), .bus_strobe(bus_strobe),
    .wdata(wdata), .rdata(rdata), .rdata_oe(rdata_oe),
    .rx_valid(rx_valid), .rx_code(rx_code), .rx_absent(rx_absent),
    .cp_tone_det(cp_tone_det), .tx_code(tx_code), .tone_on(tone_on),
    .single_tone(single_tone), .column_group(column_group),
    .call_progress_mode(call_progress_mode),
    .interrupt_tone_pin_in(pin), .interrupt_tone_pin_out(pin_out),
    .interrupt_tone_pin_oe(pin_oe));
  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  task automatic chk(input logic [3:0] g, input logic [3:0] e,
                     input string m);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask
  task automatic pulse(input logic v, input logic [3:0] c);
    @(posedge core_clk);
    #1;
    rx_valid = v;
    rx_absent = ~v;
    rx_code = c;
    @(posedge core_clk);
    #1;
    rx_valid = 1'b0;
    rx_absent = 1'b0;
    rx_code = ~c;
    repeat (2) @(posedge core_clk);
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // ------------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------------
  task automatic t_ctrl();
    h.wr(SEL_CTRL, 4'h8);
    h.wr(SEL_CTRL, 4'hD);
    h.wr(SEL_CTRL, 4'h3);
    repeat (2) @(posedge core_clk);
    chk(single_tone, 1'b1, "single");
    chk(column_group, 1'b1, "column");
    chk(call_progress_mode, 1'b1, "cp mode");
    chk(tone_on, 1'b1, "tone on");
    h.wr(SEL_CTRL, 4'h8);
    h.wr(SEL_CTRL, 4'h5);
    h.wr(SEL_CTRL, 4'h1);
    h.wr(SEL_DATA, 4'h7);
    repeat (30) @(posedge core_clk);
    chk(column_group, 1'b0, "row");
    chk(call_progress_mode, 1'b0, "tone mode");
    chk(tx_code, 4'h7, "tx code");
    chk(tone_on, 1'b1, "steady tone");
    h.rd(SEL_CTRL, s);
    chk(s[ST_TX_READY], 1'b0, "no ready");
    h.wr(SEL_CTRL, 4'h0);
    repeat (2) @(posedge core_clk);
    chk(tone_on, 1'b0, "tone off");
    $display("test ctrl done");
  endtask
  task automatic t_burst();
    h.wr(SEL_CTRL, 4'hD);
    h.wr(SEL_CTRL, 4'h0);
    h.wr(SEL_DATA, 4'h7);
    t0 = $time;
    @(posedge core_clk);
    #1;
    chk(tone_on, 1'b1, "burst tone");
    for (int i = 0; i < 100 && pin; i++) @(posedge core_clk);
    chk(tone_on, 1'b0, "pause quiet");
    t0 = ($time - t0) / 40;
    chk(t0 >= 2 * BL - 3 && t0 <= 2 * BL + 3, 1'b1, "burst");
    chk(tx_code, 4'h7, "burst code");
    h.rd(SEL_CTRL, s);
    chk(s, 4'h3, "ready");
    h.rd(SEL_CTRL, s);
    chk(s, 4'h0, "read clear");
    chk(pin, 1'b1, "released");
    h.wr(SEL_CTRL, 4'hB);
    h.wr(SEL_CTRL, 4'h0);
    h.wr(SEL_DATA, 4'h3);
    t0 = $time;
    s = 4'h0;
    for (int i = 0; i < 60 && !s[ST_TX_READY]; i++) h.rd(SEL_CTRL, s);
    t0 = ($time - t0) / 40;
    chk(t0 >= 4 * BL - 5 && t0 <= 4 * BL + 5, 1'b1, "cp burst");
    $display("test burst done");
  endtask
  task automatic t_rx();
    h.wr(SEL_CTRL, 4'h4);
    pulse(1'b1, 4'h9);
    chk(pin, 1'b0, "irq low");
    h.rd(SEL_CTRL, s);
    chk(s, 4'h5, "rx full");
    h.rd(SEL_CTRL, s);
    chk(s, 4'h0, "rx clear");
    chk(pin, 1'b1, "irq gone");
    pulse(1'b0, 4'h0);
    h.rd(SEL_CTRL, s);
    chk(s, 4'h8, "absent");
    h.rd(SEL_CTRL, s);
    chk(s, 4'h8, "absent kept");
    h.rd(SEL_DATA, s);
    chk(s, 4'h9, "rx code");
    chk(rdata_oe, 1'b1, "read drive");
    @(posedge core_clk);
    #1;
    chk(rdata_oe, 1'b0, "read release");
    $display("test rx done");
  endtask
  task automatic t_cp();
    logic p;
    h.wr(SEL_CTRL, 4'h6);
    cp_tone_det = 1'b1;
    repeat (3) @(posedge core_clk);
    p = pin;
    #1;
    cp_tone_det = 1'b0;
    repeat (3) @(posedge core_clk);
    chk(p ^ pin, 1'b1, "cp wave");
    pulse(1'b1, 4'h2);
    h.rd(SEL_CTRL, s);
    chk(s & 4'h5, 4'h0, "cp no decode");
    h.rd(SEL_DATA, s);
    chk(s, 4'h9, "cp code kept");
    $display("test cp done");
  endtask
  task automatic t_test();
    logic p;
    h.wr(SEL_CTRL, 4'h8);
    h.wr(SEL_CTRL, 4'h2);
    pulse(1'b1, 4'h4);
    p = pin;
    pulse(1'b0, 4'h0);
    chk(p ^ pin, 1'b1, "steer out");
    chk(pin_out, 1'b0, "drain only");
    $display("test steer done");
  endtask
  initial begin
    core_clk = 1'b0;
    reset_n = 1'b0;
    rx_valid = 1'b0;
    rx_absent = 1'b0;
    rx_code = 4'h0;
    cp_tone_det = 1'b0;
    err_count = 0;
    compares = 0;
    repeat (10) @(posedge core_clk);
    #1;
    reset_n = 1'b1;
    h.init();
    t_ctrl();
    t_burst();
    t_rx();
    t_cp();
    t_test();
    finish_test();
  end
  initial begin
    #(20000 * 40);
    err_count++;
    finish_test();
  end
endmodule
